/* File: hw/breakpoint_address_unit.sv */
// breakpoint address unit with wishbone register slave
`include "brk_params.svh"
`default_nettype none

module breakpoint_address_unit #(
  parameter logic [7:0] SWI_OPCODE = 8'h00
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // cpu core side
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic        cpu_addr_valid_i,
  input  wire logic        cpu_opcode_fetch_i,
  input  wire logic        cpu_instr_end_i,
  input  wire logic        return_from_interrupt_i,
  input  wire logic        monitor_mode_i,
  input  wire logic        wait_mode_i,
  // system integration side
  output logic             breakpoint_request_o,
  output logic      [15:0] break_vector_o,
  output logic      [7:0]  software_interrupt_opcode_o,
  output logic             break_state_o,
  output logic             timer_freeze_o,
  output logic             watchdog_disable_o,
  output logic             flag_clear_enable_o,
  // interrupt
  output logic             irq_o
);

  brk_pkg::brk_state_t s_q;
  brk_pkg::brk_state_t s_d;

  logic        acc;
  logic        wr;
  logic        wr_lane0;
  logic        hit;
  logic        take;
  logic [7:0]  rd;
  logic [7:0]  wb;

  always_comb begin
    s_d      = s_q;
    acc      = cyc_i & stb_i;
    wr       = acc & we_i & s_q.ack;
    wr_lane0 = wr & sel_i[0];
    wb       = dat_i[7:0];
    rd       = `BRK_RST_BYTE;
    // full address compare, halted bus never matches
    hit = s_q.break_enable_bit & s_q.armed & cpu_addr_valid_i & ~s_q.brk_state &
          (cpu_addr_i == {s_q.addr_h, s_q.addr_l});
    take = (hit & cpu_opcode_fetch_i) |
           (s_q.pend & cpu_instr_end_i & ~s_q.brk_state);

    // bus answer, one cycle after request
    s_d.ack = acc & ~s_q.ack;
    case (adr_i)
      `BRK_OFS_STATUS_CONTROL: begin
        rd[`BRK_BIT_ENABLE] = s_q.break_enable_bit;
        rd[`BRK_BIT_ACTIVE] = s_q.break_active_bit;
      end
      `BRK_OFS_ADDRESS_HIGH: rd = s_q.addr_h;
      `BRK_OFS_ADDRESS_LOW:  rd = s_q.addr_l;
      `BRK_OFS_AUXILIARY:    rd[`BRK_BIT_WDOG_DISABLE] = s_q.break_watchdog_disable;
      `BRK_OFS_WAIT_STATUS:  rd[`BRK_BIT_WAIT_EXIT] = s_q.wait_exit_by_break_flag;
      `BRK_OFS_FLAG_CONTROL: rd[`BRK_BIT_FLAG_CLEAR] = s_q.flag_clear_enable;
      `BRK_OFS_IRQ_STATUS:   rd[1:0] = s_q.irq_st;
      `BRK_OFS_IRQ_MASK:     rd[1:0] = s_q.irq_msk;
      default:               rd = `BRK_RST_BYTE;
    endcase
    s_d.rdat = (acc & ~we_i & ~s_q.ack) ? {24'h000000, rd} : `BRK_RST_WORD;

    // register writes, taking effect on the ack edge
    if (wr_lane0) begin
      case (adr_i)
        `BRK_OFS_STATUS_CONTROL: begin
          s_d.break_enable_bit = wb[`BRK_BIT_ENABLE];
          s_d.break_active_bit = wb[`BRK_BIT_ACTIVE];
          if (wb[`BRK_BIT_ACTIVE]) begin
            s_d.pend = 1'b1;
          end
        end
        `BRK_OFS_ADDRESS_HIGH: begin
          s_d.addr_h = wb;
          s_d.armed  = 1'b1;
        end
        `BRK_OFS_ADDRESS_LOW: begin
          s_d.addr_l = wb;
          s_d.armed  = 1'b1;
        end
        `BRK_OFS_AUXILIARY: s_d.break_watchdog_disable = wb[`BRK_BIT_WDOG_DISABLE];
        `BRK_OFS_WAIT_STATUS: begin
          if (!wb[`BRK_BIT_WAIT_EXIT]) begin
            s_d.wait_exit_by_break_flag = 1'b0;
          end
        end
        `BRK_OFS_FLAG_CONTROL: s_d.flag_clear_enable = wb[`BRK_BIT_FLAG_CLEAR];
        `BRK_OFS_IRQ_STATUS:   s_d.irq_st = s_q.irq_st & ~wb[1:0];
        `BRK_OFS_IRQ_MASK:     s_d.irq_msk = wb[1:0];
        default: s_d.armed = s_q.armed;
      endcase
    end

    // operand match waits for instruction end
    if (hit & ~cpu_opcode_fetch_i) begin
      s_d.pend = 1'b1;
    end
    if (hit) begin
      s_d.break_active_bit  = 1'b1;
      s_d.armed = 1'b0;
    end

    // break taken
    s_d.req = take;
    if (take) begin
      s_d.pend      = 1'b0;
      s_d.break_active_bit      = 1'b1;
      s_d.brk_state = 1'b1;
      s_d.opc       = SWI_OPCODE;
      s_d.vec       = monitor_mode_i ? `BRK_VEC_MONITOR
                                     : `BRK_VEC_NORMAL;
      s_d.irq_st[`BRK_IRQ_TAKEN] = 1'b1;
      if (wait_mode_i) begin
        s_d.wait_exit_by_break_flag = 1'b1;
        s_d.irq_st[`BRK_IRQ_WAIT_EXIT] = 1'b1;
      end
    end else if (return_from_interrupt_i & s_q.brk_state) begin
      s_d.brk_state = 1'b0;
    end

    // outputs derived from next state
    s_d.irq     = |(s_d.irq_st & s_d.irq_msk);
    s_d.freeze  = s_d.brk_state;
    s_d.cop_dis = s_d.brk_state & monitor_mode_i & s_d.break_watchdog_disable;
    s_d.clr_ok  = ~s_d.brk_state | s_d.flag_clear_enable;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q           <= '0;
      s_q.armed     <= 1'b1;
      s_q.clr_ok    <= 1'b1;
      s_q.addr_h    <= `BRK_RST_BYTE;
      s_q.addr_l    <= `BRK_RST_BYTE;
      s_q.vec       <= `BRK_RST_VEC;
      s_q.irq_st    <= `BRK_RST_IRQ;
      s_q.irq_msk   <= `BRK_RST_IRQ;
    end else begin
      s_q <= s_d;
    end
  end

  assign dat_o                       = s_q.rdat;
  assign ack_o                       = s_q.ack;
  assign breakpoint_request_o        = s_q.req;
  assign break_vector_o              = s_q.vec;
  assign software_interrupt_opcode_o = s_q.opc;
  assign break_state_o               = s_q.brk_state;
  assign timer_freeze_o              = s_q.freeze;
  assign watchdog_disable_o          = s_q.cop_dis;
  assign flag_clear_enable_o         = s_q.clr_ok;
  assign irq_o                       = s_q.irq;

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  AST_MATCH_OPCODE: assert property (
    hit && cpu_opcode_fetch_i |=> breakpoint_request_o && break_state_o)
    else $error("opcode match gave no request");

  AST_DISABLED_NO_BREAK: assert property (
    !s_q.break_enable_bit && !s_q.pend |=> !breakpoint_request_o)
    else $error("request while breaks disabled");

  AST_VECTOR: assert property (
    take |=> break_vector_o ==
      ($past(monitor_mode_i) ? `BRK_VEC_MONITOR : `BRK_VEC_NORMAL))
    else $error("wrong break vector");

  AST_FORCED: assert property (
    wr_lane0 && adr_i == `BRK_OFS_STATUS_CONTROL && wb[`BRK_BIT_ACTIVE]
    && !s_q.brk_state ##1 cpu_instr_end_i |=> breakpoint_request_o)
    else $error("forced break not taken at boundary");

  AST_RTI_ENDS: assert property (
    break_state_o && return_from_interrupt_i && !take |=> !break_state_o)
    else $error("break state survived return");

  AST_OPERAND_WAITS: assert property (
    hit && !cpu_opcode_fetch_i && !cpu_instr_end_i |=> !breakpoint_request_o)
    else $error("operand break before instruction end");

  AST_NO_REARM: assert property (
    hit |=> !s_q.armed)
    else $error("match left unit armed");

  AST_HALTED_BUS: assert property (
    !cpu_addr_valid_i && !s_q.pend |=> !breakpoint_request_o)
    else $error("break on halted bus");

  AST_FREEZE: assert property (
    breakpoint_request_o |-> timer_freeze_o && break_state_o)
    else $error("timer not frozen in break");

  AST_WDOG: assert property (
    watchdog_disable_o |-> break_state_o && s_q.break_watchdog_disable)
    else $error("watchdog disabled outside break");

  AST_CLEAR_GATE: assert property (
    break_state_o && !s_q.flag_clear_enable |-> !flag_clear_enable_o)
    else $error("flag clear allowed in break");

  AST_WAIT_FLAG: assert property (
    take && wait_mode_i |=> s_q.wait_exit_by_break_flag ##1 (s_q.wait_exit_by_break_flag || $past(wr)))
    else $error("wait exit flag not kept");

  AST_ACK_PULSE: assert property (
    ack_o
    |=> !ack_o)
    else $error("ack held longer than one cycle");

  AST_ACK_ANSWER: assert property (
    cyc_i && stb_i && !ack_o
    |=> ack_o)
    else $error("bus request not answered");

  AST_RDAT_IDLE: assert property (
    !ack_o
    |-> dat_o == `BRK_RST_WORD)
    else $error("read data outside ack cycle");

  AST_REQ_PULSE: assert property (
    breakpoint_request_o
    |=> !breakpoint_request_o)
    else $error("request longer than one cycle");

  AST_OPCODE: assert property (
    take
    |=> software_interrupt_opcode_o == SWI_OPCODE)
    else $error("wrong interrupt opcode");

  AST_ENABLE_WRITE: assert property (
    wr_lane0 && adr_i == `BRK_OFS_STATUS_CONTROL
    |=> s_q.break_enable_bit == $past(dat_i[`BRK_BIT_ENABLE]))
    else $error("enable bit not written");

  AST_ADDR_HIGH_WRITE: assert property (
    wr_lane0 && adr_i == `BRK_OFS_ADDRESS_HIGH
    |=> s_q.addr_h == $past(wb))
    else $error("high address byte not written");

  AST_ADDR_LOW_WRITE: assert property (
    wr_lane0 && adr_i == `BRK_OFS_ADDRESS_LOW
    |=> s_q.addr_l == $past(wb))
    else $error("low address byte not written");

  AST_REARM: assert property (
    wr_lane0 && !hit && (adr_i == `BRK_OFS_ADDRESS_HIGH ||
    adr_i == `BRK_OFS_ADDRESS_LOW)
    |=> s_q.armed)
    else $error("address write did not rearm");

  AST_ACTIVE_SET: assert property (
    hit
    |=> s_q.break_active_bit)
    else $error("active bit not set on match");

  AST_ACTIVE_CLEAR: assert property (
    wr_lane0 && adr_i == `BRK_OFS_STATUS_CONTROL &&
    !wb[`BRK_BIT_ACTIVE] && !hit && !take
    |=> !s_q.break_active_bit)
    else $error("active bit not cleared by write");

  AST_COMPARE_FULL: assert property (
    cpu_addr_i != {s_q.addr_h, s_q.addr_l}
    |-> !hit)
    else $error("match on differing address");

  AST_IRQ_LEVEL: assert property (
    irq_o == |(s_q.irq_st & s_q.irq_msk))
    else $error("interrupt level wrong");

  AST_IRQ_SET_WINS: assert property (
    take && wr_lane0 && adr_i == `BRK_OFS_IRQ_STATUS
    |=> s_q.irq_st[`BRK_IRQ_TAKEN])
    else $error("clear beat break status set");

  AST_WAIT_CLEAR: assert property (
    wr_lane0 && adr_i == `BRK_OFS_WAIT_STATUS &&
    !dat_i[`BRK_BIT_WAIT_EXIT] && !(take && wait_mode_i)
    |=> !s_q.wait_exit_by_break_flag)
    else $error("wait exit flag not cleared");

  AST_FLAG_CLEAR_OPEN: assert property (
    !break_state_o || s_q.flag_clear_enable
    |-> flag_clear_enable_o)
    else $error("flag clear blocked without cause");

  AST_WDOG_MONITOR: assert property (
    break_state_o && s_q.break_watchdog_disable && $past(monitor_mode_i)
    |-> watchdog_disable_o)
    else $error("watchdog left running in monitor break");

  AST_FREEZE_ENDS: assert property (
    !break_state_o
    |-> !timer_freeze_o)
    else $error("timer frozen outside break");

  AST_BREAK_HOLDS: assert property (
    break_state_o && !return_from_interrupt_i
    |=> break_state_o)
    else $error("break state ended without return");

  AST_IDLE_STAYS: assert property (
    !break_state_o && !take
    |=> !break_state_o)
    else $error("break state entered without request");

  COV_OPCODE_BREAK: cover property (hit && cpu_opcode_fetch_i ##1 take);
  COV_OPERAND_BREAK: cover property (
    hit && !cpu_opcode_fetch_i ##[1:20] breakpoint_request_o);
  COV_RTI: cover property (break_state_o ##1 !break_state_o);
  COV_IRQ: cover property (!irq_o ##1 irq_o);
  COV_FORCED: cover property (
    s_q.pend && cpu_instr_end_i ##1 breakpoint_request_o);

endmodule
`default_nettype wire

/* File: hw/brk_params.svh */
// register map and constants of the breakpoint address unit
`ifndef BRK_PARAMS_SVH
`define BRK_PARAMS_SVH

`define BRK_OFS_STATUS_CONTROL 6'h00
`define BRK_OFS_ADDRESS_HIGH   6'h04
`define BRK_OFS_ADDRESS_LOW    6'h08
`define BRK_OFS_AUXILIARY      6'h0c
`define BRK_OFS_WAIT_STATUS    6'h10
`define BRK_OFS_FLAG_CONTROL   6'h14
`define BRK_OFS_IRQ_STATUS     6'h18
`define BRK_OFS_IRQ_MASK       6'h1c

`define BRK_BIT_ENABLE         7
`define BRK_BIT_ACTIVE         6
`define BRK_BIT_WDOG_DISABLE   7
`define BRK_BIT_WAIT_EXIT      1
`define BRK_BIT_FLAG_CLEAR     7

`define BRK_IRQ_TAKEN          0
`define BRK_IRQ_WAIT_EXIT      1

`define BRK_VEC_NORMAL         16'hfffc
`define BRK_VEC_MONITOR        16'hfefc

`define BRK_RST_BYTE           8'h00
`define BRK_RST_WORD           32'h0000_0000
`define BRK_RST_VEC            16'h0000
`define BRK_RST_IRQ            2'h0

`endif

/* File: hw/brk_pkg.sv */
// types of the breakpoint address unit
`default_nettype none
package brk_pkg;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic        break_enable_bit;
    logic        break_active_bit;
    logic [7:0]  addr_h;
    logic [7:0]  addr_l;
    logic        break_watchdog_disable;
    logic        wait_exit_by_break_flag;
    logic        flag_clear_enable;
    logic        armed;
    logic        pend;
    logic        brk_state;
    logic        req;
    logic [15:0] vec;
    logic [7:0]  opc;
    logic [1:0]  irq_st;
    logic [1:0]  irq_msk;
    logic        irq;
    logic        freeze;
    logic        cop_dis;
    logic        clr_ok;
  } brk_state_t;

endpackage
`default_nettype wire

/* File: verification/cpu_core_model.sv */
// cpu core model: instruction boundaries and handler return
`default_nettype none
module cpu_core_model (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // break side
  input  wire logic       break_state_i,
  input  wire logic [3:0] dly_i,
  // cpu outputs
  output logic            instr_end_o,
  output logic            rti_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_q;
  logic [3:0] hold_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
      hold_q <= 4'h0;
      instr_end_o <= 1'b0;
      rti_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      instr_end_o <= (cnt_q == 2'h3);
      hold_q <= break_state_i ? hold_q + 4'h1 : 4'h0;
      rti_o <= break_state_i && (hold_q == dly_i);
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb_breakpoint_address_unit.sv */
// bench of the breakpoint address unit
`include "brk_params.svh"
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module tb_breakpoint_address_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [5:0] adr_i = 6'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [15:0] cpu_addr_i = 16'h0, break_vector_o, a;
  logic cpu_addr_valid_i = 1'b1, cpu_opcode_fetch_i = 1'b0;
  logic monitor_mode_i = 1'b0, wait_mode_i = 1'b0, ack_o, irq_o;
  logic cpu_instr_end_i, return_from_interrupt_i, breakpoint_request_o;
  logic break_state_o, timer_freeze_o, watchdog_disable_o;
  logic flag_clear_enable_o;
  logic [7:0] software_interrupt_opcode_o, rd;
  int errors = 0, checks_done = 0, req_cnt = 0, seed = 65377, n0, i;
  always #25 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (breakpoint_request_o === 1'b1) req_cnt++;
  breakpoint_address_unit DUT (.mclk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .cpu_addr_i, .cpu_addr_valid_i,
    .cpu_opcode_fetch_i, .cpu_instr_end_i, .return_from_interrupt_i,
    .monitor_mode_i, .wait_mode_i, .breakpoint_request_o, .break_vector_o,
    .software_interrupt_opcode_o, .break_state_o, .timer_freeze_o,
    .watchdog_disable_o, .flag_clear_enable_o, .irq_o);
  cpu_core_model cpu (.mclk_i, .rst_i, .break_state_i(break_state_o),
    .dly_i(4'hc), .instr_end_o(cpu_instr_end_i),
    .rti_o(return_from_interrupt_i));
  function automatic logic [15:0] exp_vec(input logic mon);
    return mon ? 16'hfefc : 16'hfffc;
  endfunction
  task automatic print_verdict();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [5:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, ad, 24'h0, d};
    do begin @(posedge mclk_i); n++; end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o[7:0];
    {cyc_i, stb_i} <= 2'h0;
    if (n >= 20) begin errors++; print_verdict(); end
  endtask
  task automatic hit(input logic [15:0] ad, input logic op, v, input int e);
    n0 = req_cnt;
    @(posedge mclk_i);
    {cpu_addr_i, cpu_opcode_fetch_i, cpu_addr_valid_i} <= {ad, op, v};
    @(posedge mclk_i);
    cpu_addr_i <= ad ^ 16'h8001;
    repeat (6) @(posedge mclk_i);
    `CHK(req_cnt - n0, e)
  endtask
  task automatic leave();
    for (i = 0; i < 40 && break_state_o !== 1'b0; i++) @(posedge mclk_i);
    `CHK(break_state_o, 1'b0)
    wb(1'b1, `BRK_OFS_STATUS_CONTROL, 8'h80);
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 9; k++) begin
      wb(1'b0, 6'(k * 4), 8'h00);
      `CHK(rd, 8'h00)
    end
    a = 16'($random(seed));
    wb(1'b1, `BRK_OFS_ADDRESS_HIGH, a[15:8]);
    wb(1'b1, `BRK_OFS_ADDRESS_LOW, a[7:0]);
    wb(1'b0, `BRK_OFS_ADDRESS_LOW, 8'h00);
    `CHK(rd, a[7:0])
    wb(1'b1, `BRK_OFS_IRQ_MASK, 8'h03);
    wb(1'b1, `BRK_OFS_AUXILIARY, 8'h80);
    hit(a, 1'b1, 1'b1, 0);
    wb(1'b1, `BRK_OFS_STATUS_CONTROL, 8'h80);
    hit(a, 1'b1, 1'b1, 1);
    `CHK(break_vector_o, exp_vec(1'b0))
    `CHK(software_interrupt_opcode_o, 8'h00)
    `CHK({timer_freeze_o, irq_o, flag_clear_enable_o}, 3'h6)
    `CHK(watchdog_disable_o, 1'b0)
    wb(1'b0, `BRK_OFS_STATUS_CONTROL, 8'h00);
    `CHK(rd, 8'hc0)
    leave();
    wb(1'b1, `BRK_OFS_IRQ_STATUS, 8'h03);
    @(posedge mclk_i);
    `CHK(irq_o, 1'b0)
    hit(a, 1'b1, 1'b1, 0);
    a = 16'($random(seed));
    wb(1'b1, `BRK_OFS_ADDRESS_HIGH, a[15:8]);
    wb(1'b1, `BRK_OFS_ADDRESS_LOW, a[7:0]);
    hit(a, 1'b1, 1'b0, 0);
    monitor_mode_i <= 1'b1;
    wb(1'b1, `BRK_OFS_FLAG_CONTROL, 8'h80);
    hit(a, 1'b0, 1'b1, 1);
    `CHK(break_vector_o, exp_vec(1'b1))
    `CHK(watchdog_disable_o, 1'b1)
    `CHK(flag_clear_enable_o, 1'b1)
    leave();
    wait_mode_i <= 1'b1;
    n0 = req_cnt;
    wb(1'b1, `BRK_OFS_STATUS_CONTROL, 8'hc0);
    repeat (6) @(posedge mclk_i);
    `CHK(req_cnt - n0, 1)
    wb(1'b0, `BRK_OFS_WAIT_STATUS, 8'h00);
    `CHK(rd, 8'h02)
    wb(1'b1, `BRK_OFS_WAIT_STATUS, 8'h00);
    wb(1'b0, `BRK_OFS_WAIT_STATUS, 8'h00);
    `CHK(rd, 8'h00)
    leave();
    print_verdict();
  end
endmodule
`default_nettype wire
